// ===== dual_uart_host_port_select.sv
// Dual channel serial transceiver with an asynchronous 8-bit host port
`timescale 1ns/100ps
module dual_uart_host_port_select (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic clk_en,
  input wire logic device_reset,
  input wire logic chan_a_select_n,
  input wire logic chan_b_select_n,
  input wire logic read_strobe_n,
  input wire logic write_strobe_n,
  input wire logic [2:0] addr,
  input wire logic [7:0] data_in,
  output logic [7:0] data_out,
  output logic data_oe,
  input wire logic osc_in,
  output logic osc_out,
  input wire logic serial_in_a,
  input wire logic serial_in_b,
  output logic serial_out_a,
  output logic serial_out_b,
  output logic aux_out_a_n,
  output logic aux_out_b_n,
  output logic irq_out_a,
  output logic irq_out_a_oe,
  output logic irq_out_b,
  output logic irq_out_b_oe,
  output logic write_ready
);

  logic [18:0] pin_meta;
  logic [18:0] pin_sync;
  logic rd_prev;
  logic wr_prev;
  logic osc_prev;
  logic [3:0] rst_cnt;
  host_port_pkg::host_req_t wr_req;
  logic [1:0] wr_sel;
  logic [2:0] rd_addr;
  logic [1:0] rd_sel;
  logic [7:0] rd_val [0:1];
  logic [1:0] room;
  logic [1:0] ser_out;
  logic [1:0] aux_n;
  logic [1:0] irq_lvl;
  logic [1:0] irq_en;

  // All input pins except reset_n and clk_en cross into sys_clk through two flops; the bus itself is asynchronous
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      pin_meta <= host_port_pkg::PIN_IDLE;
      pin_sync <= host_port_pkg::PIN_IDLE;
    end else if (clk_en) begin
      pin_meta <= {chan_a_select_n, chan_b_select_n, read_strobe_n, write_strobe_n,
                   addr, data_in, device_reset, osc_in, serial_in_a, serial_in_b};
      pin_sync <= pin_meta;
    end
  end

  // Decoded bus view
  wire [1:0] sel_now = {~pin_sync[17], ~pin_sync[18]};
  wire host_port_pkg::chan_sel_t chan_sel = host_port_pkg::chan_sel_t'(sel_now);
  wire rd_low = ~pin_sync[16];
  wire wr_low = ~pin_sync[15];
  wire [2:0] s_addr = pin_sync[14:12];
  wire [7:0] s_data = pin_sync[11:4];
  wire rst_pin = pin_sync[3];
  wire osc_s = pin_sync[2];
  wire [1:0] rx_s = {pin_sync[0], pin_sync[1]};
  wire single_sel = (chan_sel == host_port_pkg::SEL_A) || (chan_sel == host_port_pkg::SEL_B);
  wire wr_commit = wr_prev & ~wr_low & (wr_sel != 2'b00);
  wire rd_end = rd_prev & ~rd_low;
  wire ref_rise = osc_s & ~osc_prev;
  wire chan_reset = rst_pin && (rst_cnt == 4'(host_port_pkg::RESET_MIN_CYCLES));

  // Strobe history, captured request and reset pulse qualification
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      rd_prev <= 1'b0;
      wr_prev <= 1'b0;
      osc_prev <= 1'b0;
      rst_cnt <= 4'h0;
      wr_req <= '0;
      wr_sel <= 2'b00;
      rd_addr <= 3'h0;
      rd_sel <= 2'b00;
    end else if (clk_en) begin
      rd_prev <= rd_low;
      wr_prev <= wr_low;
      osc_prev <= osc_s;
      // Saturating count of cycles the reset pin has stayed high
      if (!rst_pin) begin
        rst_cnt <= 4'h0;
      end else if (!chan_reset) begin
        rst_cnt <= rst_cnt + 4'h1;
      end
      // Follow address, data and select while the write strobe is low
      if (wr_low) begin
        wr_req <= '{addr: s_addr, data: s_data};
        wr_sel <= sel_now;
      end else if (!wr_prev) begin
        wr_sel <= 2'b00;
      end
      if (rd_low) begin
        rd_addr <= s_addr;
        rd_sel <= single_sel ? sel_now : 2'b00;
      end
    end
  end

  // Shared read data; drive only for a single selected channel
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      data_out <= 8'h00;
    end else if (clk_en) begin
      data_out <= (chan_sel == host_port_pkg::SEL_B) ? rd_val[1] : rd_val[0];
    end
  end
  assign data_oe = rd_low & single_sel;
  assign write_ready = &room;

  generate
    for (genvar c = 0; c < 2; c++) begin : g_chan
      host_port_pkg::chan_cfg_t cfg;
      logic [7:0] fifo_mem [0:1];
      logic wptr;
      logic rptr;
      logic [1:0] fifo_cnt;
      logic [15:0] div_cnt;
      host_port_pkg::ser_state_t tx_state;
      host_port_pkg::ser_state_t rx_state;
      logic [3:0] tx_tick;
      logic [3:0] rx_tick;
      logic [2:0] tx_idx;
      logic [2:0] rx_idx;
      logic [7:0] tx_shift;
      logic [7:0] rx_shift;
      logic tx_par;
      logic tx_stop_left;
      logic tx_pin;
      logic [7:0] rx_hold;
      logic rx_ready;
      logic rx_par_cur;
      logic rx_par_err;
      logic rx_frame_err;

      wire [15:0] eff_div = (cfg.divisor == 16'h0000) ? 16'h0001 : cfg.divisor;
      wire tick16 = ref_rise && (div_cnt >= eff_div - 16'h0001);
      wire fifo_room = (fifo_cnt != 2'd2);
      wire wr_here = wr_commit & wr_sel[c];
      wire push = wr_here && (wr_req.addr == host_port_pkg::REG_DATA) && fifo_room;
      wire pop = (tx_state == host_port_pkg::SER_IDLE) && (fifo_cnt != 2'd0);
      wire tx_bit_end = tick16 && (tx_tick == host_port_pkg::BIT_LAST_TICK);
      wire rx_bit_end = tick16 && (rx_tick == host_port_pkg::BIT_LAST_TICK);
      wire rx_bit = rx_s[c];
      wire rx_done = (rx_state == host_port_pkg::SER_STOP) && rx_bit_end;
      wire rx_clear = rd_end && rd_sel[c] && (rd_addr == host_port_pkg::REG_DATA);
      wire tx_idle = (tx_state == host_port_pkg::SER_IDLE) && (fifo_cnt == 2'd0);
      wire [7:0] status = {1'b0, tx_idle, fifo_room, 1'b0, rx_frame_err, rx_par_err,
                           1'b0, rx_ready};
      // Line level per transmit state: start low, idle and stop high
      wire tx_line = (tx_state == host_port_pkg::SER_START) ? 1'b0 :
                     (tx_state == host_port_pkg::SER_DATA) ? tx_shift[0] :
                     (tx_state == host_port_pkg::SER_PARITY) ? tx_par : 1'b1;

      // Readback mux; unused offsets read zero
      assign rd_val[c] = (rd_addr == host_port_pkg::REG_DATA) ? rx_hold :
                         (rd_addr == host_port_pkg::REG_DIVISOR_LOW) ? cfg.divisor[7:0] :
                         (rd_addr == host_port_pkg::REG_DIVISOR_HIGH) ? cfg.divisor[15:8] :
                         (rd_addr == host_port_pkg::REG_LINE_CTRL) ? cfg.line_ctrl :
                         (rd_addr == host_port_pkg::REG_MODEM_CTRL) ? cfg.modem_ctrl :
                         (rd_addr == host_port_pkg::REG_LINE_STATUS) ? status :
                         (rd_addr == host_port_pkg::REG_SCRATCH) ? cfg.scratch : 8'h00;
      assign room[c] = fifo_room;
      assign ser_out[c] = tx_pin;
      assign aux_n[c] = ~cfg.modem_ctrl[host_port_pkg::MC_AUX_IRQ];
      assign irq_en[c] = cfg.modem_ctrl[host_port_pkg::MC_AUX_IRQ];
      assign irq_lvl[c] = rx_ready | tx_idle;

      // Configuration registers, divisor and the two-entry transmit buffer
      always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
          cfg <= '{host_port_pkg::DIVISOR_RESET, host_port_pkg::LINE_CTRL_RESET,
                   host_port_pkg::MODEM_CTRL_RESET, host_port_pkg::SCRATCH_RESET};
          div_cnt <= 16'h0000;
          wptr <= 1'b0;
          rptr <= 1'b0;
          fifo_cnt <= 2'd0;
          fifo_mem[0] <= 8'h00;
          fifo_mem[1] <= 8'h00;
        end else if (clk_en) begin
          if (chan_reset) begin
            cfg <= '{host_port_pkg::DIVISOR_RESET, host_port_pkg::LINE_CTRL_RESET,
                     host_port_pkg::MODEM_CTRL_RESET, host_port_pkg::SCRATCH_RESET};
            div_cnt <= 16'h0000;
            wptr <= 1'b0;
            rptr <= 1'b0;
            fifo_cnt <= 2'd0;
          end else begin
            if (ref_rise) begin
              div_cnt <= tick16 ? 16'h0000 : div_cnt + 16'h0001;
            end
            if (wr_here) begin
              case (wr_req.addr)
                host_port_pkg::REG_DIVISOR_LOW: cfg.divisor[7:0] <= wr_req.data;
                host_port_pkg::REG_DIVISOR_HIGH: cfg.divisor[15:8] <= wr_req.data;
                host_port_pkg::REG_LINE_CTRL: cfg.line_ctrl <= wr_req.data;
                host_port_pkg::REG_MODEM_CTRL: cfg.modem_ctrl <= wr_req.data;
                host_port_pkg::REG_SCRATCH: cfg.scratch <= wr_req.data;
                default: ;
              endcase
            end
            // Buffer decouples a host write from a busy shifter; a byte written while both entries are full is dropped
            if (push) begin
              fifo_mem[wptr] <= wr_req.data;
              wptr <= ~wptr;
            end
            if (pop) begin
              rptr <= ~rptr;
            end
            fifo_cnt <= fifo_cnt + {1'b0, push} - {1'b0, pop};
          end
        end
      end

      // Transmitter: start, eight data bits, optional parity, one or two stops
      always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
          tx_state <= host_port_pkg::SER_IDLE;
          tx_tick <= 4'h0;
          tx_idx <= 3'h0;
          tx_shift <= 8'h00;
          tx_par <= 1'b0;
          tx_stop_left <= 1'b0;
          tx_pin <= 1'b1;
        end else if (clk_en) begin
          tx_pin <= rst_pin ? 1'b1 : tx_line;
          if (chan_reset) begin
            tx_state <= host_port_pkg::SER_IDLE;
          end else if (pop) begin
            tx_shift <= fifo_mem[rptr];
            tx_par <= host_port_pkg::parity_bit(fifo_mem[rptr],
                                                cfg.line_ctrl[host_port_pkg::LC_PARITY_EVEN]);
            tx_tick <= 4'h0;
            tx_state <= host_port_pkg::SER_START;
          end else if (tick16 && tx_state != host_port_pkg::SER_IDLE) begin
            tx_tick <= tx_tick + 4'h1;
            if (tx_bit_end) begin
              case (tx_state)
                host_port_pkg::SER_START: begin
                  tx_idx <= 3'h0;
                  tx_state <= host_port_pkg::SER_DATA;
                end
                host_port_pkg::SER_DATA: begin
                  tx_shift <= {1'b0, tx_shift[7:1]};
                  tx_idx <= tx_idx + 3'h1;
                  tx_stop_left <= cfg.line_ctrl[host_port_pkg::LC_TWO_STOP];
                  if (tx_idx == host_port_pkg::LAST_DATA_BIT) begin
                    tx_state <= cfg.line_ctrl[host_port_pkg::LC_PARITY_EN] ?
                                host_port_pkg::SER_PARITY : host_port_pkg::SER_STOP;
                  end
                end
                host_port_pkg::SER_PARITY: tx_state <= host_port_pkg::SER_STOP;
                host_port_pkg::SER_STOP: begin
                  tx_stop_left <= 1'b0;
                  if (!tx_stop_left) begin
                    tx_state <= host_port_pkg::SER_IDLE;
                  end
                end
                default: tx_state <= host_port_pkg::SER_IDLE;
              endcase
            end
          end
        end
      end

      // Receiver: start validated at its centre, later bits sampled mid-bit
      always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
          rx_state <= host_port_pkg::SER_IDLE;
          rx_tick <= 4'h0;
          rx_idx <= 3'h0;
          rx_shift <= 8'h00;
          rx_hold <= 8'h00;
          rx_ready <= 1'b0;
          rx_par_cur <= 1'b0;
          rx_par_err <= 1'b0;
          rx_frame_err <= 1'b0;
        end else if (clk_en) begin
          // A character landing in the clearing cycle keeps ready set
          if (rx_done) begin
            rx_ready <= 1'b1;
          end else if (rx_clear || chan_reset) begin
            rx_ready <= 1'b0;
          end
          if (chan_reset) begin
            rx_hold <= 8'h00;
            rx_par_err <= 1'b0;
            rx_frame_err <= 1'b0;
          end
          if (rst_pin) begin
            rx_state <= host_port_pkg::SER_IDLE;
          end else if (rx_state == host_port_pkg::SER_IDLE) begin
            if (!rx_bit) begin
              rx_tick <= 4'h0;
              rx_state <= host_port_pkg::SER_START;
            end
          end else if (tick16) begin
            rx_tick <= rx_tick + 4'h1;
            case (rx_state)
              host_port_pkg::SER_START: begin
                if (rx_tick == host_port_pkg::START_MID_TICK) begin
                  rx_tick <= 4'h0;
                  rx_idx <= 3'h0;
                  rx_par_cur <= 1'b0;
                  rx_state <= rx_bit ? host_port_pkg::SER_IDLE : host_port_pkg::SER_DATA;
                end
              end
              host_port_pkg::SER_DATA: begin
                if (rx_bit_end) begin
                  rx_shift <= {rx_bit, rx_shift[7:1]};
                  rx_idx <= rx_idx + 3'h1;
                  if (rx_idx == host_port_pkg::LAST_DATA_BIT) begin
                    rx_state <= cfg.line_ctrl[host_port_pkg::LC_PARITY_EN] ?
                                host_port_pkg::SER_PARITY : host_port_pkg::SER_STOP;
                  end
                end
              end
              host_port_pkg::SER_PARITY: begin
                if (rx_bit_end) begin
                  rx_par_cur <= rx_bit != host_port_pkg::parity_bit(rx_shift,
                                cfg.line_ctrl[host_port_pkg::LC_PARITY_EVEN]);
                  rx_state <= host_port_pkg::SER_STOP;
                end
              end
              host_port_pkg::SER_STOP: begin
                if (rx_bit_end) begin
                  rx_hold <= rx_shift;
                  rx_par_err <= rx_par_cur;
                  rx_frame_err <= ~rx_bit;
                  rx_state <= host_port_pkg::SER_IDLE;
                end
              end
              default: rx_state <= host_port_pkg::SER_IDLE;
            endcase
          end
        end
      end
    end
  endgenerate

  // Serial side pins; rates scale with the sampled reference clock
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      osc_out <= 1'b0;
    end else if (clk_en) begin
      osc_out <= osc_s;
    end
  end
  assign serial_out_a = ser_out[0];
  assign serial_out_b = ser_out[1];
  assign aux_out_a_n = aux_n[0];
  assign aux_out_b_n = aux_n[1];
  assign irq_out_a = irq_lvl[0];
  assign irq_out_b = irq_lvl[1];
  assign irq_out_a_oe = irq_en[0];
  assign irq_out_b_oe = irq_en[1];

endmodule : dual_uart_host_port_select

// ===== dual_uart_host_port_select_tb.sv
// Self-checking bench for the dual channel host port
`timescale 1ns/100ps
module dual_uart_host_port_select_tb;
  localparam logic [1:0] SA = 2'b10;
  localparam logic [1:0] SB = 2'b01;
  localparam logic [1:0] SBOTH = 2'b00;
  logic sys_clk = 1'b0;
  logic reset_n = 1'b0;
  logic device_reset = 1'b0;
  logic [1:0] osc_cnt = 2'h0;
  logic osc_run = 1'b1;
  logic serial_in_a = 1'b1;
  logic serial_in_b = 1'b1;
  logic cs_a_n, cs_b_n, rd_n, wr_n, data_oe, oe;
  logic serial_out_a, serial_out_b, aux_out_a_n, aux_out_b_n;
  logic irq_out_a_oe, irq_out_b_oe, write_ready, irq_out_a, irq_out_b, osc_out;
  logic [2:0] addr;
  logic [7:0] data_in, data_out, q, da, db;
  integer seed = 53598;
  int bad_count = 0;
  int checked = 0;

  always #4 sys_clk = ~sys_clk;

  // Reference at a quarter of the system rate; channels cross-wired for loopback
  always @(posedge sys_clk) begin
    osc_cnt <= osc_cnt + {1'b0, osc_run};
    serial_in_b <= serial_out_a;
    serial_in_a <= serial_out_b;
  end

  dual_uart_host_port_select i_dut (.sys_clk(sys_clk), .reset_n(reset_n), .clk_en(1'b1),
    .device_reset(device_reset), .chan_a_select_n(cs_a_n), .chan_b_select_n(cs_b_n),
    .read_strobe_n(rd_n), .write_strobe_n(wr_n), .addr(addr), .data_in(data_in),
    .data_out(data_out), .data_oe(data_oe), .osc_in(osc_cnt[1]), .osc_out(osc_out),
    .serial_in_a(serial_in_a), .serial_in_b(serial_in_b), .serial_out_a(serial_out_a),
    .serial_out_b(serial_out_b), .aux_out_a_n(aux_out_a_n), .aux_out_b_n(aux_out_b_n),
    .irq_out_a(irq_out_a), .irq_out_a_oe(irq_out_a_oe), .irq_out_b(irq_out_b),
    .irq_out_b_oe(irq_out_b_oe),
    .write_ready(write_ready));

  host_cpu_model i_host (.sys_clk(sys_clk), .data_out(data_out), .data_oe(data_oe),
    .chan_a_select_n(cs_a_n), .chan_b_select_n(cs_b_n), .read_strobe_n(rd_n),
    .write_strobe_n(wr_n), .addr(addr), .data_in(data_in));

  task automatic check(input logic [7:0] seen, input logic [7:0] want);
    checked++;
    if (seen !== want) begin
      bad_count++;
      $display("ERROR at %0t: saw %h, expected %h", $time, seen, want);
    end
  endtask : check

  task automatic stop_test();
    $display("Comparisons %0d, mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : stop_test

  // Frame bits LSB first: start, data, parity or stop, then stops
  function automatic logic [11:0] frame_of(input logic [7:0] d, input logic [2:0] m);
    frame_of = {2'b11, m[0] ? (m[1] ? ^d : ~^d) : 1'b1, d, 1'b0};
  endfunction : frame_of

  // Samples the line mid-bit, 64 system cycles per bit at divisor 1
  task automatic watch_frame(input logic [7:0] d, input logic [2:0] m);
    logic [11:0] f;
    int w;
    f = frame_of(d, m);
    w = 0;
    while (serial_out_a === 1'b1 && w < 2000) begin
      @(posedge sys_clk);
      w++;
    end
    repeat (32) @(posedge sys_clk);
    for (int i = 0; i < 10 + m[0] + m[2]; i++) begin
      check({7'h00, serial_out_a}, {7'h00, f[i]});
      repeat (64) @(posedge sys_clk);
    end
  endtask : watch_frame

  // Reset pin pulse; a short one must leave the registers alone
  task automatic pulse(input int n);
    @(posedge sys_clk);
    device_reset <= 1'b1;
    repeat (n) @(posedge sys_clk);
    check({6'h00, serial_out_a, serial_out_b}, 8'h03);
    device_reset <= 1'b0;
    repeat (4) @(posedge sys_clk);
  endtask : pulse

  initial begin
    repeat (30000) @(posedge sys_clk);
    bad_count++;
    stop_test();
  end

  initial begin
    repeat (3) @(posedge sys_clk);
    reset_n <= 1'b1;
    // Defaults in both channels, reserved offset 6 included
    for (int s = 0; s < 2; s++) begin
      for (int a = 1; a < 8; a++) begin
        if (a != 5) begin
          i_host.bus_read(s ? SB : SA, a[2:0], q, oe);
          check(q, (a == 1) ? 8'h01 : 8'h00);
        end
      end
    end
    check({6'h00, aux_out_a_n, aux_out_b_n}, 8'h03);
    check({6'h00, irq_out_a, irq_out_b}, 8'h03);
    // Random bytes per channel stay apart
    repeat (4) begin
      da = 8'($random(seed));
      db = 8'($random(seed));
      i_host.bus_write(SA, host_port_pkg::REG_SCRATCH, da);
      i_host.bus_write(SB, host_port_pkg::REG_SCRATCH, db);
      i_host.bus_read(SA, host_port_pkg::REG_SCRATCH, q, oe);
      check(q, da);
      check({7'h00, oe}, 8'h01);
      i_host.bus_read(SB, host_port_pkg::REG_SCRATCH, q, oe);
      check(q, db);
    end
    // Reference clock stopped: the bus must still work, the clock copy stands still
    osc_run <= 1'b0;
    i_host.bus_write(SA, host_port_pkg::REG_SCRATCH, 8'hC3);
    check({7'h00, osc_out}, {7'h00, osc_cnt[1]});
    i_host.bus_read(SA, host_port_pkg::REG_SCRATCH, q, oe);
    osc_run <= 1'b1;
    check(q, 8'hC3);
    // Write to both, then refused reads with both and with none
    i_host.bus_write(SBOTH, host_port_pkg::REG_SCRATCH, 8'h5A);
    i_host.bus_read(SB, host_port_pkg::REG_SCRATCH, q, oe);
    check(q, 8'h5A);
    i_host.bus_read(SBOTH, host_port_pkg::REG_SCRATCH, q, oe);
    check({7'h00, oe}, 8'h00);
    i_host.bus_read(2'b11, host_port_pkg::REG_SCRATCH, q, oe);
    check({7'h00, oe}, 8'h00);
    i_host.bus_write(SA, host_port_pkg::REG_MODEM_CTRL, 8'h08);
    check({5'h00, aux_out_a_n, aux_out_b_n, irq_out_a_oe}, 8'h03);
    pulse(3);
    i_host.bus_read(SA, host_port_pkg::REG_SCRATCH, q, oe);
    check(q, 8'h5A);
    pulse(9);
    i_host.bus_read(SB, host_port_pkg::REG_SCRATCH, q, oe);
    check(q, 8'h00);
    check({6'h00, aux_out_a_n, irq_out_a_oe}, 8'h02);
    // Every line mode, A sends and B receives
    for (int m = 0; m < 8; m++) begin
      da = 8'($random(seed));
      i_host.bus_write(SBOTH, host_port_pkg::REG_LINE_CTRL, {5'h00, m[2:0]});
      check({7'h00, write_ready}, 8'h01);
      fork
        i_host.bus_write(SA, host_port_pkg::REG_DATA, da);
        watch_frame(da, m[2:0]);
      join
      i_host.bus_read(SB, host_port_pkg::REG_DATA, q, oe);
      check(q, da);
      i_host.bus_read(SB, host_port_pkg::REG_LINE_STATUS, q, oe);
      check(q & 8'h6D, 8'h60);
    end
    // Reset pin landing in a start bit must force the line back high
    i_host.bus_write(SA, host_port_pkg::REG_DATA, 8'h00);
    pulse(9);
    stop_test();
  end
endmodule : dual_uart_host_port_select_tb

// ===== host_cpu_model.sv
// Host processor model driving the asynchronous register bus
`timescale 1ns/100ps
module host_cpu_model (
  input wire logic sys_clk,
  input wire logic [7:0] data_out,
  input wire logic data_oe,
  output logic chan_a_select_n,
  output logic chan_b_select_n,
  output logic read_strobe_n,
  output logic write_strobe_n,
  output logic [2:0] addr,
  output logic [7:0] data_in
);
  logic drive = 1'b0;
  logic [7:0] wdata = 8'h00;

  // Bus level: writer, else device, else the inverse since nothing holds the lines
  assign data_in = drive ? wdata : (data_oe ? data_out : ~wdata);

  initial begin
    {chan_b_select_n, chan_a_select_n, read_strobe_n, write_strobe_n} = 4'hF;
    addr = 3'h0;
  end

  // Five-cycle phases clear the two-flop synchroniser with margin
  task automatic bus_write(input logic [1:0] sel_n, input logic [2:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    {chan_b_select_n, chan_a_select_n} <= sel_n;
    addr <= a;
    wdata <= d;
    drive <= 1'b1;
    write_strobe_n <= 1'b0;
    repeat (5) @(posedge sys_clk);
    write_strobe_n <= 1'b1;
    repeat (5) @(posedge sys_clk);
    {chan_b_select_n, chan_a_select_n} <= 2'b11;
    drive <= 1'b0;
  endtask : bus_write

  // Selects outlast the strobe so the read end still sees its channel
  task automatic bus_read(input logic [1:0] sel_n, input logic [2:0] a,
                          output logic [7:0] q, output logic oe);
    @(posedge sys_clk);
    {chan_b_select_n, chan_a_select_n} <= sel_n;
    addr <= a;
    read_strobe_n <= 1'b0;
    repeat (5) @(posedge sys_clk);
    q = data_out;
    oe = data_oe;
    read_strobe_n <= 1'b1;
    repeat (3) @(posedge sys_clk);
    {chan_b_select_n, chan_a_select_n} <= 2'b11;
    repeat (3) @(posedge sys_clk);
  endtask : bus_read
endmodule : host_cpu_model

// ===== host_port_checker.sv
// Concurrent checks on the host port pins of the dual channel transceiver
`timescale 1ns/100ps
module host_port_checker (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic device_reset,
  input wire logic chan_a_select_n,
  input wire logic chan_b_select_n,
  input wire logic read_strobe_n,
  input wire logic write_strobe_n,
  input wire logic data_oe,
  input wire logic serial_out_a,
  input wire logic serial_out_b,
  input wire logic aux_out_a_n,
  input wire logic aux_out_b_n,
  input wire logic irq_out_a_oe,
  input wire logic irq_out_b_oe,
  input wire logic write_ready
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!reset_n);

  logic [3:0] since_wr;
  logic [3:0] since_rst;

  // Cycles since a write ended or the reset pin was high; saturates so it never wraps
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      since_wr <= 4'hF;
      since_rst <= 4'hF;
    end else begin
      since_wr <= $rose(write_strobe_n) ? 4'h0 : since_wr + {3'h0, since_wr != 4'hF};
      since_rst <= device_reset ? 4'h0 : since_rst + {3'h0, since_rst != 4'hF};
    end
  end

  // Pin phases held long enough to pass the synchroniser
  sequence single_read;
    (!read_strobe_n && (chan_a_select_n != chan_b_select_n)) [*3];
  endsequence
  sequence both_read;
    (!read_strobe_n && !chan_a_select_n && !chan_b_select_n) [*3];
  endsequence
  sequence rst_short;
    device_reset [*5];
  endsequence
  sequence rst_long;
    device_reset [*8];
  endsequence

  oe_decode_a: assert property (
    data_oe == $past(!read_strobe_n && (chan_a_select_n != chan_b_select_n), 2))
    else $error("bus enable does not follow a single-channel read");
  one_read_a: assert property (single_read |-> data_oe)
    else $error("single-channel read not driven");
  both_read_a: assert property (both_read |-> !data_oe)
    else $error("bus driven while both channels selected");
  tx_hold_a: assert property (rst_short |-> serial_out_a && serial_out_b)
    else $error("transmit line not held high during reset");
  cfg_clear_a: assert property (
    rst_long |=> aux_out_a_n && aux_out_b_n && !irq_out_a_oe && !irq_out_b_oe)
    else $error("channels not returned to defaults by reset pin");
  a_aux_link_a: assert property (irq_out_a_oe == !aux_out_a_n)
    else $error("channel A aux and irq enable disagree");
  b_aux_link_a: assert property (irq_out_b_oe == !aux_out_b_n)
    else $error("channel B aux and irq enable disagree");
  aux_cause_a: assert property (
    ($changed(aux_out_a_n) || $changed(aux_out_b_n)) |-> (since_wr < 8 || since_rst < 12))
    else $error("aux output moved without a write or reset");
  ready_boot_a: assert property ($rose(reset_n) |-> write_ready)
    else $error("transmit buffers not free after reset");
endmodule : host_port_checker

bind dual_uart_host_port_select host_port_checker i_chk (
  .sys_clk(sys_clk),
  .reset_n(reset_n),
  .device_reset(device_reset),
  .chan_a_select_n(chan_a_select_n),
  .chan_b_select_n(chan_b_select_n),
  .read_strobe_n(read_strobe_n),
  .write_strobe_n(write_strobe_n),
  .data_oe(data_oe),
  .serial_out_a(serial_out_a),
  .serial_out_b(serial_out_b),
  .aux_out_a_n(aux_out_a_n),
  .aux_out_b_n(aux_out_b_n),
  .irq_out_a_oe(irq_out_a_oe),
  .irq_out_b_oe(irq_out_b_oe),
  .write_ready(write_ready)
);

// ===== host_port_pkg.sv
// Shared constants, carriers and helpers for the dual channel host port
package host_port_pkg;

  // Clock and reset qualification
  localparam int unsigned SYS_CLK_MHZ = 125;
  localparam int unsigned RESET_MIN_NS = 40;
  localparam int unsigned RESET_MIN_CYCLES = (RESET_MIN_NS * SYS_CLK_MHZ + 999) / 1000;

  // Serial timing: ticks per bit and the start bit centre
  localparam logic [3:0] BIT_LAST_TICK = 4'hF;
  localparam logic [3:0] START_MID_TICK = 4'h7;
  localparam logic [2:0] LAST_DATA_BIT = 3'h7;

  // Per-channel register offsets on the 3 address lines
  localparam logic [2:0] REG_DATA = 3'h0;
  localparam logic [2:0] REG_DIVISOR_LOW = 3'h1;
  localparam logic [2:0] REG_DIVISOR_HIGH = 3'h2;
  localparam logic [2:0] REG_LINE_CTRL = 3'h3;
  localparam logic [2:0] REG_MODEM_CTRL = 3'h4;
  localparam logic [2:0] REG_LINE_STATUS = 3'h5;
  localparam logic [2:0] REG_SCRATCH = 3'h7;

  // Field positions
  localparam int unsigned LC_PARITY_EN = 0;
  localparam int unsigned LC_PARITY_EVEN = 1;
  localparam int unsigned LC_TWO_STOP = 2;
  localparam int unsigned MC_AUX_IRQ = 3;

  // Reset values
  localparam logic [15:0] DIVISOR_RESET = 16'h0001;
  localparam logic [7:0] LINE_CTRL_RESET = 8'h00;
  localparam logic [7:0] MODEM_CTRL_RESET = 8'h00;
  localparam logic [7:0] SCRATCH_RESET = 8'h00;

  // Synchroniser idle: selects and strobes high, reset low, serial lines high
  localparam logic [18:0] PIN_IDLE = 19'h78003;

  typedef struct packed {
    logic [2:0] addr;
    logic [7:0] data;
  } host_req_t;

  typedef struct packed {
    logic [15:0] divisor;
    logic [7:0] line_ctrl;
    logic [7:0] modem_ctrl;
    logic [7:0] scratch;
  } chan_cfg_t;

  typedef enum logic [1:0] {
    SEL_NONE = 2'b00,
    SEL_A = 2'b01,
    SEL_B = 2'b10,
    SEL_BOTH = 2'b11
  } chan_sel_t;

  typedef enum logic [2:0] {
    SER_IDLE = 3'b000,
    SER_START = 3'b001,
    SER_DATA = 3'b010,
    SER_PARITY = 3'b011,
    SER_STOP = 3'b100
  } ser_state_t;

  // Parity bit for a character; odd parity unless even is set
  function automatic logic parity_bit(input logic [7:0] data, input logic even);
    parity_bit = even ? (^data) : ~(^data);
  endfunction : parity_bit

endpackage : host_port_pkg
